// [inc/apo_pkg.sv]
// Purpose: Shared constants for the absolute position output link.
// Assumes: A 200 MHz system clock on both ends.
// Notes:   Times are kept in their own units and converted to cycles here.
package apo_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 200_000_000;
   localparam int unsigned BAUD_BPS       = 9_600;
   localparam int unsigned BIT_CYCLES     = CLK_HZ / BAUD_BPS;
   localparam int unsigned FRAME_GAP_MS   = 100;
   localparam int unsigned GAP_CYCLES     = (CLK_HZ / 1000) * FRAME_GAP_MS;
   localparam int unsigned SETTLE_S       = 10;
   localparam int unsigned SETTLE_CYCLES  = CLK_HZ * SETTLE_S;
   // ----------------------------------------------------------------
   // Position and frame layout
   // ----------------------------------------------------------------
   localparam int unsigned POS_W          = 33;
   localparam int unsigned NIB_W          = 4;
   localparam int unsigned BYTE_W         = 8;
   localparam int unsigned FRAMES         = 9;
   localparam logic [3:0]  FRAME_FIRST    = 4'h1;
   localparam logic [3:0]  FRAME_LAST     = 4'h9;
   localparam int unsigned SIGN_BIT       = 32;
   localparam int unsigned UART_BITS      = 11;
   // ----------------------------------------------------------------
   // Pulse count setting, quadrature and byte buffer
   // ----------------------------------------------------------------
   localparam int unsigned PPR_W          = 14;
   localparam logic [13:0] PPR_MIN        = 14'h0001;
   localparam logic [13:0] PPR_MAX        = 14'h2000;
   localparam int unsigned ENC_W          = 17;
   localparam logic [16:0] ENC_COUNTS     = 17'h1ffff;
   localparam int unsigned FIFO_W         = 8;
   localparam int unsigned FIFO_D         = 4;

   // Even parity bit of a byte.
   function automatic logic evenPar(input logic [7:0] d);
      return ^d;
   endfunction
endpackage

// [inc/apo_link_if.sv]
// Purpose: Wires between the drive's output end and the host's receive end.
// Assumes: One clock domain; every pin is a one-way line driver.
// Notes:   Serial idles high; A, B, Z are plain levels.
`timescale 1ns/1ps
`default_nettype none
interface apo_link_if;
   logic serTx;
   logic phaseA;
   logic phaseB;
   logic phaseZ;
   modport drive (output serTx, output phaseA, output phaseB, output phaseZ);
   modport host  (input serTx, input phaseA, input phaseB, input phaseZ);
endinterface
`default_nettype wire

// [design/apo_fifo.sv]
// Purpose: Small flop FIFO with valid/ready on both sides.
// Assumes: One clock; push and pop may happen in the same cycle.
// Notes:   Depth must be a power of two.
`timescale 1ns/1ps
`default_nettype none
module apo_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wrPtr_reg;
   logic [AW-1:0]    rdPtr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   // Handshakes and flags.
   assign inReady  = (count_reg != (AW+1)'(DEPTH));
   assign outValid = (count_reg != '0);
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   assign outData  = mem_reg[rdPtr_reg];

   // Storage writes.
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_reg[wrPtr_reg] <= inData;
      end
   end

   // Pointers and fill level.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) wrPtr_reg <= wrPtr_reg + 1'b1;
         if (pop) rdPtr_reg <= rdPtr_reg + 1'b1;
         if (push && !pop) count_reg <= count_reg + 1'b1;
         else if (pop && !push) count_reg <= count_reg - 1'b1;
      end
   end
endmodule
`default_nettype wire

// [design/apo_drive_end.sv]
// Purpose: Drive end: serial absolute position frames and A/B/Z pulses.
// Assumes: encPos is the 33-bit signed count, low 17 bits in one turn.
// Notes:   Bytes pass a 4-deep FIFO between framer and UART.
// How it works
// - 33-bit position in nine bytes, 100 ms apart.
// - Sequence repeats forever from reset.
// - Frames 1-8 carry ascending position nibbles.
// - High nibble holds frame number 1-9.
// - Frame 9 nibble is sign extension.
// - 9600 baud, 8 bits LSB first, even parity.
// - Host ignores data for first 10 s.
// - A and B give setting pulses per turn.
// - Z gives one pulse per turn.
// - Forward A leads B; reverse A lags.
// - Host counts all edges for 4x.
// - A/B/Z may lag the absolute position.
// - Origin read needs shaft standing still.
// - Pulse setting taken only at power-up.
`timescale 1ns/1ps
`default_nettype none
module apo_drive_end (
   input  wire logic                        mclk,
   input  wire logic                        sys_rst,
   input  wire logic [apo_pkg::POS_W-1:0]   encPos,
   input  wire logic [apo_pkg::PPR_W-1:0]   monitorPulseCountSetting,
   apo_link_if.drive                        link
);
   import apo_pkg::*;

   // ----------------------------------------------------------------
   // Setting capture
   // ----------------------------------------------------------------
   logic [PPR_W-1:0] ppr_reg;
   logic             pprLoaded_reg;

   // The setting is sampled once after reset release only.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ppr_reg       <= PPR_MAX;
         pprLoaded_reg <= 1'b0;
      end else if (!pprLoaded_reg) begin
         pprLoaded_reg <= 1'b1;
         if (monitorPulseCountSetting < PPR_MIN) ppr_reg <= PPR_MIN;
         else if (monitorPulseCountSetting > PPR_MAX) ppr_reg <= PPR_MAX;
         else ppr_reg <= monitorPulseCountSetting;
      end
   end

   // ----------------------------------------------------------------
   // Frame builder
   // ----------------------------------------------------------------
   logic [31:0]       gapCnt_reg;
   logic [3:0]        frame_reg;
   logic [POS_W-1:0]  snap_reg;
   logic              pend_reg;
   logic [BYTE_W-1:0] fByte;
   logic              fReady;
   logic [NIB_W-1:0]  nib;

   // Nibble of the frozen snapshot for this frame, or sign fill.
   always_comb begin
      if (frame_reg == FRAME_LAST) begin
         nib = {NIB_W{snap_reg[SIGN_BIT]}};
      end else begin
         nib = snap_reg[(frame_reg - 4'h1) * NIB_W +: NIB_W];
      end
   end
   assign fByte = {frame_reg, nib};

   // Every gap period one byte is offered; frame 1 takes a new snapshot.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         gapCnt_reg <= '0;
         frame_reg  <= FRAME_FIRST;
         snap_reg   <= '0;
         pend_reg   <= 1'b0;
      end else begin
         if (pend_reg && fReady) begin
            pend_reg <= 1'b0;
            if (frame_reg == FRAME_LAST) frame_reg <= FRAME_FIRST;
            else frame_reg <= frame_reg + 4'h1;
         end
         // The first byte goes out right after reset, then one per gap period.
         if (gapCnt_reg == GAP_CYCLES - 1) begin
            gapCnt_reg <= '0;
         end else begin
            gapCnt_reg <= gapCnt_reg + 32'h1;
         end
         if (gapCnt_reg == '0) begin
            if (!pend_reg || fReady) begin
               pend_reg <= 1'b1;
               if ((pend_reg && frame_reg == FRAME_LAST) ||
                   (!pend_reg && frame_reg == FRAME_FIRST)) begin
                  snap_reg <= encPos;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Byte buffer and serialiser
   // ----------------------------------------------------------------
   logic [BYTE_W-1:0] qData;
   logic              qValid;
   logic              qReady;
   logic [UART_BITS-1:0] shift_reg;
   logic [3:0]        bitLeft_reg;
   logic [15:0]       baud_reg;
   logic              tx_reg;

   apo_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) uFifo (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .inData   (fByte),
      .inValid  (pend_reg),
      .inReady  (fReady),
      .outData  (qData),
      .outValid (qValid),
      .outReady (qReady)
   );

   assign qReady = (bitLeft_reg == 4'h0);

   // Start, 8 data LSB first, even parity, stop.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_reg   <= '1;
         bitLeft_reg <= 4'h0;
         baud_reg    <= '0;
         tx_reg      <= 1'b1;
      end else if (bitLeft_reg == 4'h0) begin
         tx_reg <= 1'b1;
         if (qValid) begin
            shift_reg   <= {1'b1, evenPar(qData), qData, 1'b0};
            bitLeft_reg <= 4'(UART_BITS);
            baud_reg    <= '0;
         end
      end else if (baud_reg == 16'h0) begin
         tx_reg      <= shift_reg[0];
         shift_reg   <= {1'b1, shift_reg[UART_BITS-1:1]};
         baud_reg    <= 16'(BIT_CYCLES - 1);
         bitLeft_reg <= bitLeft_reg - 4'h1;
      end else begin
         baud_reg <= baud_reg - 16'h1;
      end
   end
   // Note: the last bit's stop time runs while bitLeft is zero idle high.

   // ----------------------------------------------------------------
   // Quadrature generator
   // ----------------------------------------------------------------
   logic [ENC_W+PPR_W-1:0] scaled;
   logic [PPR_W+1:0]       qTarget;
   logic [PPR_W+1:0]       qCnt_reg;
   logic [1:0]             qState_reg;
   logic                   zOut_reg;
   logic                   phA_reg;
   logic                   phB_reg;
   logic [PPR_W+1:0]       span;
   logic [PPR_W+1:0]       ahead;

   // Target quarter count = angle * 4 * ppr / 2^17.
   assign scaled  = encPos[ENC_W-1:0] * ppr_reg;
   assign qTarget = (PPR_W+2)'(scaled[ENC_W+PPR_W-1:ENC_W-2]);

   // Quarter steps per turn, and the distance to the target going forward.
   assign span  = {ppr_reg, 2'b00};
   assign ahead = (qTarget >= qCnt_reg) ? qTarget - qCnt_reg : qTarget + span - qCnt_reg;

   // One step per cycle along the shorter way round, wrapping at one turn.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         qCnt_reg   <= '0;
         qState_reg <= 2'h0;
      end else if (pprLoaded_reg && qCnt_reg != qTarget) begin
         if (ahead <= (span >> 1)) begin
            qCnt_reg   <= (qCnt_reg == span - 1'b1) ? '0 : qCnt_reg + 1'b1;
            qState_reg <= qState_reg + 2'h1;
         end else begin
            qCnt_reg   <= (qCnt_reg == '0) ? span - 1'b1 : qCnt_reg - 1'b1;
            qState_reg <= qState_reg - 2'h1;
         end
      end
   end

   // Index marks count zero, also while passing through it.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         zOut_reg <= 1'b0;
      end else begin
         zOut_reg <= (qCnt_reg == '0);
      end
   end

   // Gray order 00,10,11,01: A leads B when counting up.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         phA_reg <= 1'b0;
         phB_reg <= 1'b0;
      end else begin
         phA_reg <= (qState_reg == 2'h1) || (qState_reg == 2'h2);
         phB_reg <= qState_reg[1];
      end
   end
   assign link.phaseA = phA_reg;
   assign link.phaseB = phB_reg;
   assign link.phaseZ = zOut_reg;
   assign link.serTx  = tx_reg;
endmodule
`default_nettype wire

// [design/apo_host_end.sv]
// Purpose: Host end: receives position frames and counts quadrature edges.
// Assumes: Link pins come from outside and are synchronised here.
// Notes:   Positions before the settle time are dropped.
`timescale 1ns/1ps
`default_nettype none
module apo_host_end #(
   parameter int unsigned SETTLE = apo_pkg::SETTLE_CYCLES
) (
   input  wire logic                      mclk,
   input  wire logic                      sys_rst,
   apo_link_if.host                       link,
   output logic [apo_pkg::POS_W-1:0]      posOut,
   output logic                           posValid,
   output logic                           parityErr,
   output logic [31:0]                    edgeCount,
   output logic                           zSeen
);
   import apo_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] s1_reg, s2_reg, s3_reg, st_reg;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_reg <= 4'h8; s2_reg <= 4'h8; s3_reg <= 4'h8; st_reg <= 4'h8;
      end else begin
         s1_reg <= {link.serTx, link.phaseA, link.phaseB, link.phaseZ};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < 4; i++) if (s2_reg[i] == s3_reg[i]) st_reg[i] <= s3_reg[i];
      end
   end

   // ----------------------------------------------------------------
   // Settle timer and quadrature counter (all edges)
   // ----------------------------------------------------------------
   logic [31:0] settle_reg;
   logic [1:0]  ab_reg;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         settle_reg <= '0;
         ab_reg     <= 2'h0;
         edgeCount  <= '0;
         zSeen      <= 1'b0;
      end else begin
         if (settle_reg < SETTLE) settle_reg <= settle_reg + 32'h1;
         ab_reg <= st_reg[2:1];
         zSeen  <= st_reg[0];
         if (ab_reg != st_reg[2:1]) begin
            if ((ab_reg[1] ^ st_reg[2]) ? (st_reg[1] != st_reg[2]) :
                                          (st_reg[1] == st_reg[2]))
               edgeCount <= edgeCount + 32'h1;
            else
               edgeCount <= edgeCount - 32'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // UART receiver and frame assembly
   // ----------------------------------------------------------------
   logic [15:0]       bCnt_reg;
   logic [3:0]        bIdx_reg;
   logic [9:0]        rx_reg;
   logic [POS_W-1:0]  acc_reg;
   logic [3:0]        expect_reg;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         bCnt_reg <= '0; bIdx_reg <= 4'h0; rx_reg <= '0; acc_reg <= '0;
         expect_reg <= FRAME_FIRST; posOut <= '0; posValid <= 1'b0; parityErr <= 1'b0;
      end else begin
         posValid <= 1'b0;
         if (bIdx_reg == 4'h0) begin
            if (!st_reg[3]) begin
               bIdx_reg <= 4'h1;
               bCnt_reg <= 16'(BIT_CYCLES + BIT_CYCLES / 2);
            end
         end else if (bCnt_reg != 16'h0) begin
            bCnt_reg <= bCnt_reg - 16'h1;
         end else if (bIdx_reg <= 4'ha) begin
            rx_reg   <= {st_reg[3], rx_reg[9:1]};
            bCnt_reg <= 16'(BIT_CYCLES - 1);
            bIdx_reg <= bIdx_reg + 4'h1;
         end else begin
            bIdx_reg <= 4'h0;
            parityErr <= (evenPar(rx_reg[7:0]) != rx_reg[8]) || !rx_reg[9];
            if ((evenPar(rx_reg[7:0]) == rx_reg[8]) && rx_reg[9]) begin
               if (rx_reg[7:4] != expect_reg) begin
                  expect_reg <= FRAME_FIRST;
               end else if (rx_reg[7:4] == FRAME_LAST) begin
                  expect_reg <= FRAME_FIRST;
                  posOut   <= {rx_reg[0], acc_reg[31:0]};
                  posValid <= (settle_reg >= SETTLE);
               end else begin
                  acc_reg[(rx_reg[7:4] - 4'h1) * NIB_W +: NIB_W] <= rx_reg[3:0];
                  expect_reg <= expect_reg + 4'h1;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// [tb/apo_link_assertions.sv]
// Purpose: Concurrent checks on the wires between drive end and host end.
// Assumes: One clock; every serial bit lasts BIT_CYCLES cycles.
// Notes:   A small tracker samples each serial bit in its middle.
`timescale 1ns/1ps
`default_nettype none
module apo_link_assertions (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic serTx,
   input wire logic phaseA,
   input wire logic phaseB,
   input wire logic phaseZ
);
   import apo_pkg::*;
   localparam int unsigned HALF = BIT_CYCLES / 2;
   logic        busy_reg;
   logic [15:0] cnt_reg;
   logic [3:0]  bitIx_reg;
   logic [10:0] bits_reg;
   logic [3:0]  lastFrame_reg;
   logic [31:0] runLen_reg;
   logic        stopMid;
   logic [3:0]  frameSeen;
   // The middle of the stop bit is where a whole byte has been sampled.
   assign stopMid   = busy_reg && bitIx_reg == 4'ha && cnt_reg == HALF;
   assign frameSeen = bits_reg[8:5];
   // Follows one character from its start edge to its stop bit.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_reg  <= 1'b0;
         cnt_reg   <= 16'h0;
         bitIx_reg <= 4'h0;
      end else if (!busy_reg) begin
         busy_reg  <= !serTx;
         cnt_reg   <= 16'h1;
         bitIx_reg <= 4'h0;
      end else if (cnt_reg == BIT_CYCLES - 1) begin
         cnt_reg   <= 16'h0;
         bitIx_reg <= bitIx_reg + 4'h1;
         busy_reg  <= bitIx_reg != 4'ha;
      end else begin
         cnt_reg <= cnt_reg + 16'h1;
      end
   end
   // Keeps the mid-bit samples of the character.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         bits_reg <= 11'h0;
      end else if (busy_reg && cnt_reg == HALF) begin
         bits_reg[bitIx_reg] <= serTx;
      end
   end
   // Remembers the last frame number; zero means none seen yet.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         lastFrame_reg <= 4'h0;
      end else if (stopMid) begin
         lastFrame_reg <= frameSeen;
      end
   end
   // Counts samples since the serial line last changed level.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         runLen_reg <= 32'h0;
      end else if ($changed(serTx)) begin
         runLen_reg <= 32'h1;
      end else begin
         runLen_reg <= runLen_reg + 32'h1;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence s_idleHigh;
      serTx;
   endsequence
   sequence s_startSoon;
      ##[1:1000] !serTx;
   endsequence
   chk_idle_then_start: assert property ($fell(sys_rst) |-> s_idleHigh ##0 s_startSoon)
      else $error("serial line did not idle high and then start");
   chk_gray_step: assert property (!($changed(phaseA) && $changed(phaseB)))
      else $error("phase A and B changed together");
   chk_z_home: assert property (phaseZ |-> !phaseA && !phaseB)
      else $error("index pulse away from the zero phase state");
   chk_low_whole: assert property ($rose(serTx) |-> runLen_reg % BIT_CYCLES == 0)
      else $error("low run is not a whole number of bits");
   chk_start_low: assert property (busy_reg && bitIx_reg == 4'h0 && cnt_reg == HALF |-> !serTx)
      else $error("start bit not low in its middle");
   chk_stop_high: assert property (stopMid |-> serTx)
      else $error("stop bit not high");
   chk_even_par: assert property (stopMid |-> bits_reg[9] == ^bits_reg[8:1])
      else $error("parity bit is not even");
   chk_frame_num: assert property (stopMid |-> frameSeen inside {[4'h1:4'h9]})
      else $error("frame number out of range");
   chk_frame_next: assert property (stopMid && lastFrame_reg != 4'h0 |->
      frameSeen == (lastFrame_reg == 4'h9 ? 4'h1 : lastFrame_reg + 4'h1))
      else $error("frame out of order");
   chk_sign_nib: assert property (stopMid && frameSeen == 4'h9 |-> bits_reg[4:1] inside {4'h0, 4'hf})
      else $error("last frame nibble is not a sign extension");
endmodule
`default_nettype wire

// [tb/tb.sv]
// Purpose: Joins drive end and host end and checks the link behaviour.
// Assumes: Byte gaps stay long, so only the first byte's head is seen.
// Notes:   The byte buffer is checked inside the drive end.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import apo_pkg::*;
   localparam int          LIMIT = 120000;
   localparam logic [32:0] POS0  = 33'h00000000c;
   logic        mclk;
   logic        sys_rst;
   logic [32:0] encPos;
   logic [13:0] pulseSet;
   logic [32:0] posOut;
   logic        posValid;
   logic        parityErr;
   logic [31:0] edgeCount;
   logic        zSeen;
   int          bad_count = 0;
   int          n_checks = 0;
   int          cycles = 0;
   int          zRises = 0;
   apo_link_if linkIf ();
   apo_drive_end apo_drive_end_inst (.mclk(mclk), .sys_rst(sys_rst), .encPos(encPos),
      .monitorPulseCountSetting(pulseSet), .link(linkIf.drive));
   apo_host_end #(.SETTLE(100)) apo_host_end_inst (.mclk(mclk), .sys_rst(sys_rst),
      .link(linkIf.host), .posOut(posOut), .posValid(posValid), .parityErr(parityErr),
      .edgeCount(edgeCount), .zSeen(zSeen));
   apo_link_assertions apo_link_assertions_inst (.mclk(mclk), .sys_rst(sys_rst),
      .serTx(linkIf.serTx), .phaseA(linkIf.phaseA), .phaseB(linkIf.phaseB),
      .phaseZ(linkIf.phaseZ));
   // Makes the 200 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Compares a seen value with the expected one and counts both outcomes.
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // Prints the counts and the verdict, then stops the run.
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Counts index pulses and cuts a hung run short.
   always @(posedge mclk) begin
      cycles++;
      if ($rose(linkIf.phaseZ)) begin
         zRises++;
      end
      if (cycles == LIMIT) begin
         bad_count++;
         end_of_test();
      end
   end
   // First byte: start bit, then the low position nibble LSB first.
   task automatic serial_test();
      int i;
      i = 0;
      while (linkIf.serTx !== 1'b0 && i < 1000) begin
         @(posedge mclk);
         i++;
      end
      check(i < 1000, 1'b1);
      repeat (BIT_CYCLES / 2) @(posedge mclk);
      check(linkIf.serTx, 1'b0);
      for (int b = 0; b < 4; b++) begin
         repeat (BIT_CYCLES) @(posedge mclk);
         check(linkIf.serTx, POS0[b]);
      end
      $display("serial test done");
   endtask
   // Moves forward, back and one full turn; the late setting change must not count.
   task automatic quad_test();
      logic [31:0] e0;
      int          z0;
      repeat (300) @(posedge mclk);
      pulseSet <= PPR_MIN;
      e0 = edgeCount;
      encPos <= encPos + 33'd40;
      repeat (100) @(posedge mclk);
      check(edgeCount - e0, 33'd10);
      encPos <= encPos - 33'd80;
      repeat (100) @(posedge mclk);
      check(edgeCount - e0, 33'h0fffffff6);
      z0 = zRises;
      repeat (4) begin
         encPos <= encPos + 33'h000008000;
         repeat (8250) @(posedge mclk);
      end
      check(edgeCount - e0, 33'h000007ff6);
      check(zRises - z0, 33'd1);
      $display("quadrature test done");
   endtask
   // The first byte has left the buffer; no stray flags on the host side.
   task automatic buffer_test();
      @(posedge mclk);
      #1;
      check(apo_drive_end_inst.uFifo.outValid, 1'b0);
      check(apo_drive_end_inst.uFifo.inReady, 1'b1);
      check(parityErr, 1'b0);
      check(posValid, 1'b0);
      $display("buffer test done");
   endtask
   // Main sequence: reset, link tests side by side, then the FIFO.
   initial begin
      sys_rst   = 1'b1;
      encPos    = POS0;
      pulseSet  = PPR_MAX;
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      fork
         serial_test();
         quad_test();
      join
      buffer_test();
      end_of_test();
   end
endmodule
`default_nettype wire
